// ---- hdl/ebh_ext_bus.sv ----
// external bus master with ready handshake and hold arbitration
// Notes on behaviour
// - ready high adds wait, low ends cycle
// - mux bus adds turnaround, optional tristate wait
// - gap two clocks mux+tristate, zero demux without tristate
// - programmed wait states before first ready sample
// - command delay postpones strobe leading edge
// - finish running cycle before granting hold
// - chip selects released to pull-ups
// - regain request only after hold acknowledge
// - regain starts only when hold returns high
// - hold may drop without regain request
`timescale 1ns/1ps
`default_nettype none
module ebh_ext_bus (
  input wire logic clock,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link side, on the link clock
  input wire logic linkClock,
  output logic sysClockOut,
  input wire logic readyN,
  input wire logic holdN,
  output logic holdAcknowledgeOutN,
  output logic busRegainRequestN,
  output logic [ebh_pkg::NCS-1:0] chipSelectLinesN,
  output logic [ebh_pkg::NCS-1:0] chipSelectOe,
  output logic [ebh_pkg::AW-1:0] addrOut,
  output logic addrOe,
  output logic [ebh_pkg::DW-1:0] dataOut,
  input wire logic [ebh_pkg::DW-1:0] dataIn,
  output logic dataOe,
  output logic aleOut,
  output logic rdN,
  output logic wrN,
  output logic ctlOe
);
  // ==================== apb domain registers
  logic [ebh_pkg::CTRL_W-1:0] ctrl_r; // mode and timing options
  logic [ebh_pkg::AW-1:0] addr_r; // held stable while busy
  logic [ebh_pkg::DW-1:0] wdata_r; // held stable while busy
  logic dirRead_r; // direction of the pending cycle
  logic busy_r; // a cycle is on its way
  logic startPulse; // one clock, launches a cycle
  logic donePulse; // back from the link domain
  logic [1:0] stSync; // ack and regain state, synchronised
  logic [ebh_pkg::DW-1:0] rdata_r; // link domain, stable once done
  logic setup; // apb setup phase
  logic acc; // apb access completes
  assign setup = psel && !penable;
  assign acc = psel && penable && pready;
  assign startPulse = acc && pwrite && paddr == ebh_pkg::OFF_CMD && !busy_r;
  // ==================== apb answer, one wait-free access
  // answer is prepared in setup so every apb output is a flip-flop
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      unique case (paddr)
        ebh_pkg::OFF_CTRL: prdata <= {24'h00_0000, ctrl_r};
        ebh_pkg::OFF_ADDR: prdata <= {16'h0000, addr_r};
        ebh_pkg::OFF_WDATA: prdata <= {16'h0000, wdata_r};
        ebh_pkg::OFF_CMD: prdata <= {31'h0000_0000, dirRead_r};
        ebh_pkg::OFF_STATUS: prdata <= {29'h0000_0000, stSync, busy_r};
        ebh_pkg::OFF_RDATA: prdata <= {16'h0000, rdata_r};
        default: pslverr <= 1'b1; // unmapped address
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
  // ==================== apb writes
  // options and cycle words are frozen while busy so the link sees them settled
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= ebh_pkg::CTRL_RST;
      addr_r <= 16'h0000;
      wdata_r <= 16'h0000;
      dirRead_r <= 1'b0;
    end else if (acc && pwrite && !busy_r) begin
      if (paddr == ebh_pkg::OFF_CTRL) ctrl_r <= pwdata[ebh_pkg::CTRL_W-1:0];
      if (paddr == ebh_pkg::OFF_ADDR) addr_r <= pwdata[ebh_pkg::AW-1:0];
      if (paddr == ebh_pkg::OFF_WDATA) wdata_r <= pwdata[ebh_pkg::DW-1:0];
      if (paddr == ebh_pkg::OFF_CMD) dirRead_r <= pwdata[ebh_pkg::CMD_READ];
    end
  end
  // ==================== busy flag
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) busy_r <= 1'b0;
    else if (startPulse) busy_r <= 1'b1;
    else if (donePulse) busy_r <= 1'b0;
  end
  // ==================== crossings
  logic linkStart; // start event in link domain
  logic linkDone; // done event from link domain
  ebh_toggle_xfer uStart (
    .srcClock(clock),
    .dstClock(linkClock),
    .rstn(rstn),
    .srcPulse(startPulse),
    .dstPulse(linkStart)
  );
  ebh_toggle_xfer uDone (
    .srcClock(linkClock),
    .dstClock(clock),
    .rstn(rstn),
    .srcPulse(linkDone),
    .dstPulse(donePulse)
  );
  ebh_sync #(.W(2)) uStat (
    .clock(clock),
    .rstn(rstn),
    .din({~busRegainRequestN, ~holdAcknowledgeOutN}),
    .dout(stSync)
  );
  logic [ebh_pkg::CTRL_W-1:0] cfg; // options, link domain
  ebh_sync #(.W(ebh_pkg::CTRL_W)) uCfg (
    .clock(linkClock),
    .rstn(rstn),
    .din(ctrl_r),
    .dout(cfg)
  );
  // pins come in asynchronously: two flops before any use
  // hold and ready cross inverted so the cleared chain reads as idle pins;
  // otherwise the first step after reset would see a false hold request
  logic [ebh_pkg::DW+1:0] pins; // {hold asserted, ready asserted, data}
  ebh_sync #(.W(ebh_pkg::DW + 2)) uPins (
    .clock(linkClock),
    .rstn(rstn),
    .din({~holdN, ~readyN, dataIn}),
    .dout(pins)
  );
  logic holdS; // hold input, low requests the bus
  logic readyS; // ready input, low ends the cycle
  logic cfgMux; // multiplexed bus
  logic cfgTri; // tristate wait state
  logic cfgDly; // command delay
  logic [3:0] cfgWaits; // memory_cycle_wait_count
  assign holdS = !pins[ebh_pkg::DW+1];
  assign readyS = !pins[ebh_pkg::DW];
  assign cfgMux = cfg[ebh_pkg::CTRL_MUX];
  assign cfgTri = cfg[ebh_pkg::CTRL_TRI];
  assign cfgDly = cfg[ebh_pkg::CTRL_DLY];
  assign cfgWaits = cfg[ebh_pkg::CTRL_WAIT_LO+3:ebh_pkg::CTRL_WAIT_LO];
  // ==================== output clock
  // link clock is twice the bus rate, so one link period is half_clock_period
  logic step; // this edge raises sysClockOut
  assign step = !sysClockOut;
  always_ff @(posedge linkClock or negedge rstn) begin
    if (!rstn) sysClockOut <= 1'b0;
    else sysClockOut <= ~sysClockOut;
  end
  // ==================== bus engine
  ebh_pkg::ebh_state_type state_r; // engine state
  logic pending_r; // start seen, cycle not yet begun
  logic [3:0] waitCnt_r; // remaining wait states
  logic enterCmd; // strobe phase begins at this edge
  logic endCycle; // ready sampled low in strobe phase
  logic grant; // hand the bus away at this edge
  logic regain; // take the bus back at this edge
  assign enterCmd = step && ((state_r == ebh_pkg::ST_ADDR && cfgWaits == ebh_pkg::WAIT_ZERO)
    || (state_r == ebh_pkg::ST_WAITS && waitCnt_r == ebh_pkg::WAIT_ONE));
  assign endCycle = step && state_r == ebh_pkg::ST_CMD && !readyS;
  // grant only from idle, so a running cycle always finishes first
  assign grant = step && state_r == ebh_pkg::ST_IDLE && !holdS;
  assign regain = step && state_r == ebh_pkg::ST_HELD && holdS;
  assign linkDone = endCycle;
  // state sequencing, one step per sysClockOut period
  always_ff @(posedge linkClock or negedge rstn) begin
    if (!rstn) state_r <= ebh_pkg::ST_IDLE;
    else if (step) begin
      unique case (state_r)
        ebh_pkg::ST_IDLE: begin
          if (!holdS) state_r <= ebh_pkg::ST_HELD;
          else if (pending_r) state_r <= ebh_pkg::ST_ADDR;
        end
        ebh_pkg::ST_ADDR: begin
          if (enterCmd) state_r <= ebh_pkg::ST_CMD;
          else state_r <= ebh_pkg::ST_WAITS;
        end
        ebh_pkg::ST_WAITS: begin
          if (enterCmd) state_r <= ebh_pkg::ST_CMD;
        end
        ebh_pkg::ST_CMD: begin
          // high ready stays here as one more wait state
          if (!readyS) begin
            if (cfgMux) state_r <= ebh_pkg::ST_TURN;
            else if (cfgTri) state_r <= ebh_pkg::ST_TRIW;
            else state_r <= ebh_pkg::ST_IDLE;
          end
        end
        ebh_pkg::ST_TURN: begin
          if (cfgTri) state_r <= ebh_pkg::ST_TRIW;
          else state_r <= ebh_pkg::ST_IDLE;
        end
        ebh_pkg::ST_TRIW: state_r <= ebh_pkg::ST_IDLE;
        ebh_pkg::ST_HELD: begin
          if (holdS) state_r <= ebh_pkg::ST_REGAIN;
        end
        ebh_pkg::ST_REGAIN: state_r <= ebh_pkg::ST_IDLE;
      endcase
    end
  end
  // ==================== pending request and wait count
  always_ff @(posedge linkClock or negedge rstn) begin
    if (!rstn) pending_r <= 1'b0;
    else if (linkStart) pending_r <= 1'b1;
    else if (step && state_r == ebh_pkg::ST_IDLE && holdS) pending_r <= 1'b0;
  end
  always_ff @(posedge linkClock or negedge rstn) begin
    if (!rstn) waitCnt_r <= ebh_pkg::WAIT_ZERO;
    else if (step && state_r == ebh_pkg::ST_ADDR) waitCnt_r <= cfgWaits;
    else if (step && state_r == ebh_pkg::ST_WAITS) waitCnt_r <= waitCnt_r - 4'h1;
  end
  // ==================== strobes
  logic cmdLate_r; // delayed strobe due half a bus clock later
  always_ff @(posedge linkClock or negedge rstn) begin
    if (!rstn) begin
      rdN <= 1'b1;
      wrN <= 1'b1;
      cmdLate_r <= 1'b0;
    end else if (enterCmd && !cfgDly) begin
      rdN <= !dirRead_r;
      wrN <= dirRead_r;
    end else if (enterCmd) begin
      cmdLate_r <= 1'b1;
    end else if (cmdLate_r) begin
      cmdLate_r <= 1'b0;
      rdN <= !dirRead_r;
      wrN <= dirRead_r;
    end else if (endCycle) begin
      // rising strobe lets the peripheral drop ready
      rdN <= 1'b1;
      wrN <= 1'b1;
    end
  end
  // ==================== address latch and read capture
  always_ff @(posedge linkClock or negedge rstn) begin
    if (!rstn) aleOut <= 1'b0;
    else if (step) aleOut <= state_r == ebh_pkg::ST_IDLE && holdS && pending_r;
  end
  always_ff @(posedge linkClock or negedge rstn) begin
    if (!rstn) rdata_r <= 16'h0000;
    else if (endCycle && dirRead_r) rdata_r <= pins[ebh_pkg::DW-1:0];
  end
  // ==================== address and data drivers
  // in mux mode the address rides on the data lines during the latch phase
  always_ff @(posedge linkClock or negedge rstn) begin
    if (!rstn) begin
      addrOut <= 16'h0000;
      dataOut <= 16'h0000;
      dataOe <= 1'b0;
    end else if (step) begin
      unique case (state_r)
        ebh_pkg::ST_IDLE: begin
          addrOut <= addr_r;
          dataOut <= cfgMux ? addr_r : wdata_r;
          dataOe <= holdS && pending_r && (cfgMux || !dirRead_r);
        end
        ebh_pkg::ST_ADDR: begin
          dataOut <= wdata_r;
          dataOe <= !dirRead_r;
        end
        ebh_pkg::ST_CMD: begin
          if (!readyS) dataOe <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end
  // ==================== chip selects
  // one line per address window; released to the pull-ups while held
  genvar gi;
  for (gi = 0; gi < ebh_pkg::NCS; gi++) begin : gCs
    always_ff @(posedge linkClock or negedge rstn) begin
      if (!rstn) chipSelectLinesN[gi] <= 1'b1;
      else if (step && state_r == ebh_pkg::ST_IDLE && holdS && pending_r)
        chipSelectLinesN[gi] <= addr_r[ebh_pkg::AW-1:ebh_pkg::CS_LSB] != 3'(gi);
      else if (endCycle || grant) chipSelectLinesN[gi] <= 1'b1;
    end
    always_ff @(posedge linkClock or negedge rstn) begin
      if (!rstn) chipSelectOe[gi] <= 1'b1;
      else if (grant) chipSelectOe[gi] <= 1'b0;
      else if (regain) chipSelectOe[gi] <= 1'b1;
    end
  end
  // ==================== arbitration outputs
  always_ff @(posedge linkClock or negedge rstn) begin
    if (!rstn) begin
      addrOe <= 1'b1;
      ctlOe <= 1'b1;
      holdAcknowledgeOutN <= 1'b1;
    end else if (grant) begin
      addrOe <= 1'b0;
      ctlOe <= 1'b0;
      holdAcknowledgeOutN <= 1'b0;
    end else if (regain) begin
      addrOe <= 1'b1;
      ctlOe <= 1'b1;
      holdAcknowledgeOutN <= 1'b1;
    end
  end
  // regain request only while held, so never before acknowledge is out
  always_ff @(posedge linkClock or negedge rstn) begin
    if (!rstn) busRegainRequestN <= 1'b1;
    else if (regain) busRegainRequestN <= 1'b1;
    else if (step && state_r == ebh_pkg::ST_HELD && pending_r)
      busRegainRequestN <= 1'b0;
  end
endmodule // ebh_ext_bus
`default_nettype wire

// ---- hdl/ebh_pkg.sv ----
// constants shared by the external bus, ready and hold arbitration block
package ebh_pkg;
  // ==================== register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00; // bus mode and timing options
  localparam logic [7:0] OFF_ADDR = 8'h04; // address of the next cycle
  localparam logic [7:0] OFF_WDATA = 8'h08; // write data of the next cycle
  localparam logic [7:0] OFF_CMD = 8'h0c; // start a cycle
  localparam logic [7:0] OFF_STATUS = 8'h10; // busy and arbitration state
  localparam logic [7:0] OFF_RDATA = 8'h14; // data of the last read
  // ==================== control field positions
  localparam int CTRL_MUX = 0; // multiplexed address/data bus
  localparam int CTRL_TRI = 1; // tristate wait state enable
  localparam int CTRL_DLY = 2; // command delay enable
  localparam int CTRL_WAIT_LO = 4; // memory_cycle_wait_count low bit
  localparam int CTRL_W = 8; // control register width
  localparam int CMD_READ = 0; // 1 reads, 0 writes
  localparam int ST_BUSY = 0; // cycle pending or running
  localparam int ST_HOLD_ACKNOWLEDGE_OUT = 1; // bus granted away
  localparam int ST_BUS_REGAIN_REQUEST = 2; // regain request active
  // ==================== widths and reset values
  localparam int AW = 16; // external address width
  localparam int DW = 16; // external data width
  localparam int NCS = 5; // chip select lines
  localparam int CS_LSB = 13; // address bits that pick a chip select
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00; // demux, no delays
  localparam logic [3:0] WAIT_ONE = 4'h1; // last wait state count
  localparam logic [3:0] WAIT_ZERO = 4'h0; // no wait states
  // ==================== bus engine states
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_WAITS = 8'h04,
    ST_CMD = 8'h08,
    ST_TURN = 8'h10,
    ST_TRIW = 8'h20,
    ST_HELD = 8'h40,
    ST_REGAIN = 8'h80
  } ebh_state_type;
endpackage

// ---- hdl/ebh_sync.sv ----
// two flip-flop level synchroniser of configurable width
`timescale 1ns/1ps
`default_nettype none
module ebh_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  // ==================== sync chain
  logic [W-1:0] meta_r; // first stage, read only by the second
  // each bit crosses on its own; multi-bit words must be quasi-static
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule // ebh_sync
`default_nettype wire

// ---- hdl/ebh_toggle_xfer.sv ----
// toggle based event crossing from one clock to another
`timescale 1ns/1ps
`default_nettype none
module ebh_toggle_xfer (
  input wire logic srcClock,
  input wire logic dstClock,
  input wire logic rstn,
  input wire logic srcPulse,
  output logic dstPulse
);
  // ==================== source side
  logic tog_r; // flips once per event
  always_ff @(posedge srcClock or negedge rstn) begin
    if (!rstn) tog_r <= 1'b0;
    else if (srcPulse) tog_r <= ~tog_r;
  end
  // ==================== destination side
  logic meta_r; // first stage, read only by sync_r
  logic sync_r; // settled toggle
  logic last_r; // previous settled toggle
  always_ff @(posedge dstClock or negedge rstn) begin
    if (!rstn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= tog_r;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end
  // events closer than the crossing latency would merge; busy prevents that
  assign dstPulse = sync_r ^ last_r;
endmodule // ebh_toggle_xfer
`default_nettype wire

// ---- verification/ebh_ext_bus_chk.sv ----
// checker of the external bus block ports
`timescale 1ns/1ps
`default_nettype none
module ebh_ext_bus_chk (
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic linkClock,
  input wire logic readyN,
  input wire logic holdN,
  input wire logic holdAcknowledgeOutN,
  input wire logic busRegainRequestN,
  input wire logic [ebh_pkg::NCS-1:0] chipSelectOe,
  input wire logic addrOe,
  input wire logic ctlOe,
  input wire logic aleOut,
  input wire logic rdN,
  input wire logic wrN
);
  // ==================== sequences
  // ale stands one bus step, two link edges
  sequence aleStep_s;
    ##1 aleOut ##1 !aleOut;
  endsequence
  // apb answer is a one-cycle pulse
  sequence apbAns_s;
    pready ##1 !pready;
  endsequence
  // ==================== hold arbitration
  cs_float_a: assert property (@(posedge linkClock) disable iff (!rstn)
    !holdAcknowledgeOutN |-> chipSelectOe == '0 && !addrOe && !ctlOe)
    else $error("lines driven while bus granted away");
  lines_driven_a: assert property (@(posedge linkClock) disable iff (!rstn)
    holdAcknowledgeOutN |-> ctlOe && addrOe)
    else $error("lines floating while bus owned");
  regain_held_a: assert property (@(posedge linkClock) disable iff (!rstn)
    !busRegainRequestN |-> !holdAcknowledgeOutN)
    else $error("regain request without grant");
  grant_idle_a: assert property (@(posedge linkClock) disable iff (!rstn)
    $fell(holdAcknowledgeOutN) |-> $past(rdN) && $past(wrN))
    else $error("bus granted during a strobe");
  regain_start_a: assert property (@(posedge linkClock) disable iff (!rstn)
    $rose(holdAcknowledgeOutN) |-> $past(holdN, 2) || $past(holdN, 3))
    else $error("bus retaken while hold still low");
  // ==================== ready handshake, ale width and apb answer
  ready_wait_a: assert property (@(posedge linkClock) disable iff (!rstn)
    (!(rdN && wrN) && readyN) [*4] |=> !(rdN && wrN))
    else $error("strobe ended with ready high");
  ready_end_a: assert property (@(posedge linkClock) disable iff (!rstn)
    !(rdN && wrN) && !readyN |-> ##[0:6] (rdN && wrN))
    else $error("strobe kept after ready low");
  ale_step_a: assert property (@(posedge linkClock) disable iff (!rstn)
    $rose(aleOut) |-> aleStep_s)
    else $error("ale not one bus step");
  apb_ready_a: assert property (@(posedge clock) disable iff (!rstn)
    psel && !penable |=> apbAns_s)
    else $error("apb answer not one access cycle");
endmodule // ebh_ext_bus_chk

bind ebh_ext_bus ebh_ext_bus_chk i_ebh_ext_bus_chk (.clock, .rstn, .psel, .penable, .pready,
  .linkClock, .readyN, .holdN, .holdAcknowledgeOutN, .busRegainRequestN, .chipSelectOe,
  .addrOe, .ctlOe, .aleOut, .rdN, .wrN);
`default_nettype wire

// ---- verification/ebh_far_mem.sv ----
// far-side memory model answering the external bus
`timescale 1ns/1ps
`default_nettype none
module ebh_far_mem (
  input wire logic linkClock,
  input wire logic rstn,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic [15:0] dataBus,
  input wire logic [3:0] latency,
  output logic readyN,
  output logic [15:0] memData,
  output logic [15:0] lastWr
);
  // ==================== ready answer
  logic [3:0] waitCnt; // link edges spent in the strobe
  // ready low after latency edges, kept until the strobe ends
  always_ff @(posedge linkClock or negedge rstn) begin
    if (!rstn) begin
      waitCnt <= 4'h0;
      readyN <= 1'b1;
    end else if (rdN && wrN) begin
      // dropped only at strobe end, so async ready is long enough
      waitCnt <= 4'h0;
      readyN <= 1'b1;
    end else if (waitCnt >= latency) begin
      readyN <= 1'b0;
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
  // ==================== data
  // released lines flip every edge so a stale value never passes
  always_ff @(posedge linkClock or negedge rstn) begin
    if (!rstn) begin
      memData <= 16'h0000;
      lastWr <= 16'h0000;
    end else begin
      memData <= !rdN ? {12'hc3a, latency} : ~memData;
      if (!wrN) begin
        lastWr <= dataBus;
      end
    end
  end
endmodule // ebh_far_mem
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench of the external bus block
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==================== signals
  logic clock, rstn, psel, penable, pwrite, linkClock, holdN, readyN;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, e, sysClockOut, holdAcknowledgeOutN, busRegainRequestN;
  logic [ebh_pkg::NCS-1:0] chipSelectLinesN, chipSelectOe;
  logic [15:0] addrOut, dataOut, memData, lastWr, dataBus;
  logic addrOe, dataOe, aleOut, rdN, wrN, ctlOe;
  logic [3:0] memLat; // far-side answer latency
  logic [ebh_pkg::NCS-1:0] csAtStb; // selects as the strobe falls
  logic [15:0] addrAtStb; // address as the strobe falls
  logic clkAtStb; // bus clock level just after the strobe falls
  int num_errors, tests_run, strobeLen;
  realtime tAle, tStb; // ale fall and strobe fall
  assign dataBus = dataOe ? dataOut : memData; // wire level of the data lines
  // ==================== clocks and monitors
  always #2.5 clock = ~clock;
  // link clock offset so its phase is unrelated
  initial begin
    linkClock = 1'b0;
    #1.3;
    forever #40 linkClock = ~linkClock;
  end
  always @(negedge aleOut) tAle = $realtime;
  // bus clock moves on every link edge, so it is read once it has settled
  always @(negedge rdN or negedge wrN) begin
    tStb = $realtime;
    csAtStb = chipSelectLinesN;
    addrAtStb = addrOut;
    #1 clkAtStb = sysClockOut;
  end
  always @(posedge linkClock) if (!rdN || !wrN) strobeLen++;
  ebh_ext_bus i_ebh_ext_bus (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .linkClock, .sysClockOut, .readyN, .holdN,
    .holdAcknowledgeOutN, .busRegainRequestN, .chipSelectLinesN, .chipSelectOe, .addrOut,
    .addrOe, .dataOut, .dataIn(dataBus), .dataOe, .aleOut, .rdN, .wrN, .ctlOe);
  ebh_far_mem i_ebh_far_mem (.linkClock, .rstn, .rdN, .wrN, .dataBus, .latency(memLat),
    .readyN, .memData, .lastWr);
  // ==================== shared tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("mismatches %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one apb transfer, request held until pready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      end_sim;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // poll status until the masked bits match
  task wait_status(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      apb(1'b0, ebh_pkg::OFF_STATUS, 32'h0);
      n++;
    end while ((q & m) !== v && n < 400);
    if (n >= 400) begin
      num_errors++;
      end_sim;
    end
  endtask
  // ==================== scenarios
  task t_regs;
    apb(1'b0, ebh_pkg::OFF_CTRL, 32'h0);
    chk(q, {24'h0, ebh_pkg::CTRL_RST});
    apb(1'b1, 8'h1c, 32'hffff);
    chk(32'(e), 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk({q[30:0], e}, 32'h1);
  endtask
  // one bus cycle with given options and far-side latency
  task t_cycle(input logic [7:0] c, input logic r, input logic [15:0] a, input logic [15:0] d,
    input logic [3:0] lat);
    memLat <= lat;
    apb(1'b1, ebh_pkg::OFF_CTRL, {24'h0, c});
    apb(1'b1, ebh_pkg::OFF_ADDR, {16'h0, a});
    apb(1'b1, ebh_pkg::OFF_WDATA, {16'h0, d});
    strobeLen = 0;
    apb(1'b1, ebh_pkg::OFF_CMD, {31'h0, r});
    wait_status(32'h1, 32'h0);
    chk(32'(strobeLen > int'(lat)), 32'h1);
    chk(32'($rtoi((tStb - tAle) / 80.0 + 0.5)), 32'(2 * c[7:4] + c[2]));
    chk(32'(clkAtStb), 32'(!c[2]));
    chk({16'h0, addrAtStb}, {16'h0, a});
    chk({27'h0, csAtStb}, {27'h0, ~(5'h01 << a[15:13])});
    if (r) begin
      apb(1'b0, ebh_pkg::OFF_RDATA, 32'h0);
      chk(q, {16'h0, 12'hc3a, lat});
    end else begin
      chk({16'h0, lastWr}, {16'h0, d});
    end
  endtask
  // other master takes and returns an idle bus unasked
  task t_hold_idle;
    holdN <= 1'b0;
    wait_status(32'h2, 32'h2);
    chk({27'h0, chipSelectOe}, 32'h0);
    chk({addrOe, ctlOe, holdAcknowledgeOutN, busRegainRequestN}, 32'h1);
    holdN <= 1'b1;
    wait_status(32'h2, 32'h0);
    chk({addrOe, ctlOe, busRegainRequestN}, 32'h7);
  endtask
  // hold during a slow cycle, then a pending start asks the bus back
  task t_hold_busy;
    int n;
    memLat <= 4'h8;
    apb(1'b1, ebh_pkg::OFF_CTRL, 32'h0);
    apb(1'b1, ebh_pkg::OFF_CMD, 32'h1);
    n = 0;
    while (rdN !== 1'b0 && n < 200) begin
      @(posedge clock);
      n++;
    end
    if (n >= 200) begin
      num_errors++;
      end_sim;
    end
    holdN <= 1'b0;
    wait_status(32'h3, 32'h2);
    apb(1'b1, ebh_pkg::OFF_CMD, 32'h1);
    wait_status(32'h4, 32'h4);
    chk(32'(holdAcknowledgeOutN), 32'h0);
    holdN <= 1'b1;
    wait_status(32'h7, 32'h0);
    chk({busRegainRequestN, holdAcknowledgeOutN, ctlOe}, 32'h7);
  endtask
  // ==================== main sequence
  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    holdN = 1'b1;
    memLat = 4'h0;
    num_errors = 0;
    tests_run = 0;
    strobeLen = 0;
    repeat (5) @(posedge clock);
    repeat (2) @(posedge linkClock);
    @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge linkClock);
    @(posedge clock);
    t_regs;
    t_cycle(8'h00, 1'b1, 16'h1234, 16'h0000, 4'h0);
    t_cycle(8'h27, 1'b0, 16'h2468, 16'hbeef, 4'h3);
    t_cycle(8'h11, 1'b1, 16'h4321, 16'h0000, 4'h6);
    t_cycle(8'h06, 1'b0, 16'h8ace, 16'h5a5a, 4'h1);
    t_hold_idle;
    t_hold_busy;
    end_sim;
  end
  // overall limit against a hang
  initial begin
    #300000;
    num_errors++;
    end_sim;
  end
endmodule // tb
`default_nettype wire
